/* File: hdl/agen_pkg.sv */
// constants and types shared by the address generator
package agen_pkg;

	localparam int ADDR_W = 20;
	localparam logic [19:0] ADDR_RESET = 20'h00000;
	localparam logic [3:0] TOP_NIBBLE = 4'hf;
	localparam logic [3:0] ZERO_NIBBLE = 4'h0;
	// call table region base (entries are two-byte words)
	localparam logic [19:0] CALL_TABLE_BASE = 20'h00080;
	// short direct window base
	localparam logic [19:0] SHORT_DIRECT_BASE = 20'hffe20;
	// special register region base
	localparam logic [19:0] SPECIAL_REG_BASE = 20'hfff00;
	localparam logic [15:0] STACK_CALL_STEP = 16'h0004;
	localparam logic [15:0] STACK_POP_STEP = 16'h0002;
	localparam logic [15:0] STACK_PUSH_STEP = 16'h0002;
	// there is no load path for the pointer, so it must start inside ram or every access faults
	localparam logic [15:0] SP_RESET = 16'hfe00;
	// internal ram limits within the top 64 KB, default covers f000 to feff only
	localparam logic [15:0] RAM_LOW = 16'hf000;
	localparam logic [15:0] RAM_HIGH = 16'hfeff;

	// branch target modes
	typedef enum logic [5:0] {
		BR_NONE     = 6'b000001,
		BR_REL8     = 6'b000010,
		BR_REL16    = 6'b000100,
		BR_IMM20    = 6'b001000,
		BR_IMM16    = 6'b010000,
		BR_REGPAIR  = 6'b100000
	} branch_mode_e;

	// data operand modes
	typedef enum logic [3:0] {
		OP_NONE      = 4'd0,
		OP_DIRECT    = 4'd1,
		OP_SHORT     = 4'd2,
		OP_SHORT_W   = 4'd3,
		OP_SPECIAL   = 4'd4,
		OP_SPECIAL_W = 4'd5,
		OP_INDIRECT  = 4'd6,
		OP_BASED_RP  = 4'd7,
		OP_BASED_SP  = 4'd8,
		OP_WORD_IDX8 = 4'd9,
		OP_WORD_BC   = 4'd10,
		OP_HL_IDX    = 4'd11,
		OP_STACK     = 4'd12
	} operand_mode_e;

	// stack operations
	typedef enum logic [2:0] {
		STK_NONE = 3'd0,
		STK_PUSH = 3'd1,
		STK_POP  = 3'd2,
		STK_CALL = 3'd3,
		STK_RET  = 3'd4
	} stack_op_e;

	// table-call sequencer
	typedef enum logic [2:0] {
		TC_IDLE = 3'b001,
		TC_LOW  = 3'b010,
		TC_HIGH = 3'b100
	} table_state_e;

endpackage

/* File: hdl/reg_select.sv */
// register file reader: picks 8-bit register and pair of current bank
`timescale 1ns/10ps
`default_nettype none
module reg_select
	import agen_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// bank contents, registers x a c b e d l h
	input  wire logic [63:0] bank_regs,
	// selectors
	input  wire logic [2:0]  byte_sel,
	input  wire logic [1:0]  pair_sel,
	// registered outputs
	output var  logic [7:0]  byte_val,
	output var  logic [15:0] pair_val
);

	logic [7:0] regs [8];

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_split
			assign regs[g] = bank_regs[g*8 +: 8];
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			byte_val <= 8'h00;
			pair_val <= 16'h0000;
		end else begin
			byte_val <= regs[byte_sel];
			pair_val <= {regs[{pair_sel, 1'b1}], regs[{pair_sel, 1'b0}]};
		end
	end

endmodule
`default_nettype wire

/* File: hdl/cpu_address_generation.sv */
// address generator for branch targets, operands and the stack pointer
// What this block does
// - relative branch: next pc plus signed displacement
// - pc-relative target only for branch instructions
// - immediate target 20-bit, or 16-bit with zero nibble
// - table call: 5-bit index reads word target
// - table-call target stays in lowest 64 KB
// - register branch: pair plus code upper nibble
// - implied operand only for unsigned multiply
// - 3-bit selects byte reg, 2-bit selects pair
// - direct: 16-bit immediate in top 64 KB
// - segment prefix supplies upper nibble from register
// - short direct: 8-bit field into fixed window
// - short direct word form even addresses only
// - special register: 8-bit field, top 256 bytes
// - special register word form even addresses only
// - indirect via second or main pointer pair
// - based: base plus 8 or 16-bit offset
// - based variants; stack form has no prefix
// - based indexed: main pair plus index byte
// - stack addressed through stack pointer automatically
// - push, pop, call and return accesses start inside internal ram
// - call lowers stack pointer by four
// - pop reads two bytes, raises pointer by two
`timescale 1ns/10ps
`default_nettype none
module cpu_address_generation
	import agen_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// branch request from decoder
	input  wire logic        branch_req,
	input  wire logic [5:0]  branch_mode,
	input  wire logic        branch_instr,
	input  wire logic [19:0] next_pc,
	input  wire logic [19:0] branch_imm,
	input  wire logic [3:0]  code_upper_nibble,
	input  wire logic [1:0]  branch_pair_sel,
	input  wire logic        call_via_pair,
	// table call request and program memory word fetch
	input  wire logic        table_call_instr,
	input  wire logic [4:0]  table_index,
	input  wire logic [7:0]  fetch_data,
	input  wire logic        fetch_valid,
	// operand request from decoder
	input  wire logic        operand_req,
	input  wire logic [3:0]  operand_mode,
	input  wire logic        segment_prefix,
	input  wire logic [3:0]  data_upper_nibble_reg,
	input  wire logic [15:0] operand_imm,
	input  wire logic [7:0]  operand_byte,
	input  wire logic        pointer_is_main,
	input  wire logic        index_is_c,
	input  wire logic        unsigned_multiply_instr,
	input  wire logic [2:0]  reg_field,
	input  wire logic [1:0]  pair_field,
	// register bank contents
	input  wire logic [63:0] bank_regs,
	// stack requests
	input  wire logic        stack_req,
	input  wire logic [2:0]  stack_op,
	// branch outcome
	output logic             pc_load,
	output logic [19:0]      pc_target,
	// table fetch address
	output logic             fetch_req,
	output logic [19:0]      fetch_addr,
	// operand outcome
	output logic             operand_valid,
	output logic [19:0]      operand_addr,
	output logic             implied_multiplier,
	output logic [7:0]       reg_byte,
	output logic [15:0]      reg_pair,
	// stack outcome
	output logic             stack_valid,
	output logic [19:0]      stack_addr,
	output logic [15:0]      stack_pointer,
	output logic             stack_fault
);

	// ****************************************
	// register reads
	// ****************************************
	logic [15:0] pair_bc;
	logic [15:0] pair_de;
	logic [15:0] pair_hl;
	logic [7:0]  reg_b;
	logic [7:0]  reg_c;

	assign pair_bc = bank_regs[31:16];
	assign pair_de = bank_regs[47:32];
	assign pair_hl = bank_regs[63:48];
	assign reg_c = bank_regs[23:16];
	assign reg_b = bank_regs[31:24];

	reg_select u_reg_select (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.bank_regs (bank_regs),
		.byte_sel  (reg_field),
		.pair_sel  (pair_field),
		.byte_val  (reg_byte),
		.pair_val  (reg_pair)
	);

	// ****************************************
	// branch targets
	// ****************************************
	logic [15:0] branch_pair;
	logic [19:0] next_branch_target;
	logic        next_branch_ok;

	assign branch_pair = bank_regs[{branch_pair_sel, 4'h0} +: 16];

	always_comb begin
		next_branch_target = next_pc;
		next_branch_ok = 1'b0;
		case (branch_mode_e'(branch_mode))
			BR_REL8: begin
				next_branch_ok = branch_instr;
				next_branch_target = next_pc + {{12{branch_imm[7]}}, branch_imm[7:0]};
			end
			BR_REL16: begin
				next_branch_ok = branch_instr;
				next_branch_target = next_pc + {{4{branch_imm[15]}}, branch_imm[15:0]};
			end
			BR_IMM20: begin
				next_branch_ok = 1'b1;
				next_branch_target = branch_imm;
			end
			BR_IMM16: begin
				next_branch_ok = 1'b1;
				next_branch_target = {ZERO_NIBBLE, branch_imm[15:0]};
			end
			BR_REGPAIR: begin
				// only call via any pair or branch via accumulator pair
				next_branch_ok = call_via_pair || (branch_pair_sel == 2'd0);
				next_branch_target = {code_upper_nibble, branch_pair};
			end
			default: begin
				next_branch_ok = 1'b0;
			end
		endcase
	end

	// ****************************************
	// table call sequencer
	// ****************************************
	table_state_e tc_state;
	logic [7:0]   tc_low;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tc_state <= TC_IDLE;
			tc_low <= 8'h00;
			fetch_req <= 1'b0;
			fetch_addr <= ADDR_RESET;
		end else begin
			case (tc_state)
				TC_IDLE: begin
					if (table_call_instr) begin
						fetch_req <= 1'b1;
						fetch_addr <= CALL_TABLE_BASE + {14'h0000, table_index, 1'b0};
						tc_state <= TC_LOW;
					end
				end
				TC_LOW: begin
					if (fetch_valid) begin
						tc_low <= fetch_data;
						fetch_addr <= fetch_addr + 20'h00001;
						tc_state <= TC_HIGH;
					end
				end
				TC_HIGH: begin
					if (fetch_valid) begin
						fetch_req <= 1'b0;
						tc_state <= TC_IDLE;
					end
				end
				default: begin
					tc_state <= TC_IDLE;
					fetch_req <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc_load <= 1'b0;
			pc_target <= ADDR_RESET;
		end else if (tc_state == TC_HIGH && fetch_valid) begin
			pc_load <= 1'b1;
			pc_target <= {ZERO_NIBBLE, fetch_data, tc_low};
		end else begin
			pc_load <= branch_req && next_branch_ok;
			if (branch_req && next_branch_ok)
				pc_target <= next_branch_target;
		end
	end

	// ****************************************
	// operand addresses
	// ****************************************
	logic [3:0]  upper;
	logic [15:0] pointer;
	logic [7:0]  index8;
	logic [15:0] next_low;
	logic [19:0] next_operand;
	logic        next_operand_ok;

	// prefix swaps the forced top region for the register nibble
	assign upper = segment_prefix ? data_upper_nibble_reg : TOP_NIBBLE;
	assign pointer = pointer_is_main ? pair_hl : pair_de;
	assign index8 = index_is_c ? reg_c : reg_b;

	always_comb begin
		next_low = 16'h0000;
		next_operand = ADDR_RESET;
		next_operand_ok = 1'b1;
		case (operand_mode_e'(operand_mode))
			OP_DIRECT:    next_operand = {upper, operand_imm};
			OP_SHORT:     next_operand = SHORT_DIRECT_BASE + {12'h000, operand_byte};
			OP_SHORT_W:   next_operand = SHORT_DIRECT_BASE + {12'h000, operand_byte[7:1], 1'b0};
			OP_SPECIAL:   next_operand = SPECIAL_REG_BASE + {12'h000, operand_byte};
			OP_SPECIAL_W: next_operand = SPECIAL_REG_BASE + {12'h000, operand_byte[7:1], 1'b0};
			OP_INDIRECT:  next_operand = {upper, pointer};
			OP_BASED_RP: begin
				next_low = pointer + {8'h00, operand_byte};
				next_operand = {upper, next_low};
			end
			OP_BASED_SP: begin
				next_low = stack_pointer + {8'h00, operand_byte};
				next_operand = {TOP_NIBBLE, next_low};
			end
			OP_WORD_IDX8: begin
				next_low = operand_imm + {8'h00, index8};
				next_operand = {upper, next_low};
			end
			OP_WORD_BC: begin
				next_low = operand_imm + pair_bc;
				next_operand = {upper, next_low};
			end
			OP_HL_IDX: begin
				next_low = pair_hl + {8'h00, index8};
				next_operand = {upper, next_low};
			end
			OP_STACK:     next_operand = {TOP_NIBBLE, stack_pointer};
			default:      next_operand_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			operand_valid <= 1'b0;
			operand_addr <= ADDR_RESET;
			implied_multiplier <= 1'b0;
		end else begin
			operand_valid <= operand_req && next_operand_ok;
			implied_multiplier <= operand_req && unsigned_multiply_instr;
			if (operand_req && next_operand_ok)
				operand_addr <= next_operand;
		end
	end

	// ****************************************
	// stack pointer
	// ****************************************
	logic [15:0] next_sp;
	logic [15:0] next_stack_low;

	always_comb begin
		next_sp = stack_pointer;
		next_stack_low = stack_pointer;
		case (stack_op_e'(stack_op))
			STK_PUSH: begin
				next_sp = stack_pointer - STACK_PUSH_STEP;
				next_stack_low = next_sp;
			end
			STK_POP: begin
				next_sp = stack_pointer + STACK_POP_STEP;
				next_stack_low = stack_pointer;
			end
			STK_CALL: begin
				next_sp = stack_pointer - STACK_CALL_STEP;
				next_stack_low = next_sp;
			end
			STK_RET: begin
				next_sp = stack_pointer + STACK_CALL_STEP;
				next_stack_low = stack_pointer;
			end
			default: begin
				next_sp = stack_pointer;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stack_pointer <= SP_RESET;
			stack_valid <= 1'b0;
			stack_addr <= ADDR_RESET;
			stack_fault <= 1'b0;
		end else begin
			stack_valid <= 1'b0;
			stack_fault <= 1'b0;
			if (stack_req && stack_op != STK_NONE) begin
				// outside ram the access is flagged, never issued, and the pointer kept
				if (next_stack_low < RAM_LOW || next_stack_low > RAM_HIGH) begin
					stack_fault <= 1'b1;
				end else begin
					stack_valid <= 1'b1;
					stack_pointer <= next_sp;
				end
				stack_addr <= {TOP_NIBBLE, next_stack_low};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	imm16_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		branch_req && branch_mode == BR_IMM16 |=> pc_load && pc_target[19:16] == 4'h0)
		else $error("16-bit target upper nibble not zero");
	rel_only_branch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		branch_req && !branch_instr && (branch_mode == BR_REL8 || branch_mode == BR_REL16)
		&& tc_state != TC_HIGH |=> !pc_load)
		else $error("relative target used by non-branch");
	rel8_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		branch_req && branch_instr && branch_mode == BR_REL8 && tc_state != TC_HIGH
		|=> pc_target == $past(next_pc) + {{12{$past(branch_imm[7])}}, $past(branch_imm[7:0])})
		else $error("relative target sum wrong");
	table_low64k_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tc_state == TC_HIGH && fetch_valid |=> pc_load && pc_target[19:16] == 4'h0)
		else $error("table target above 64 KB");
	short_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		operand_req && operand_mode == OP_SHORT |=> operand_addr >= 20'hffe20 && operand_addr <= 20'hfff1f)
		else $error("short direct outside window");
	special_even_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		operand_req && operand_mode == OP_SPECIAL_W |=> operand_addr[0] == 1'b0 && operand_addr[19:8] == 12'hfff)
		else $error("special word address not even");
	direct_top_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		operand_req && operand_mode == OP_DIRECT && !segment_prefix |=> operand_addr[19:16] == 4'hf)
		else $error("direct access left top region");
	call_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stack_req && stack_op == STK_CALL ##1 !stack_fault |-> stack_pointer == $past(stack_pointer) - 16'h0004)
		else $error("call did not lower pointer by four");
	pop_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stack_req && stack_op == STK_POP ##1 !stack_fault |-> stack_pointer == $past(stack_pointer) + 16'h0002)
		else $error("pop did not raise pointer by two");
	stack_ram_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stack_valid |-> stack_addr[19:16] == 4'hf && stack_addr[15:0] >= RAM_LOW && stack_addr[15:0] <= RAM_HIGH)
		else $error("stack access outside internal ram");

endmodule
`default_nettype wire

/* File: verification/table_memory.sv */
// partner model: program memory answering table fetches one byte at a time
`timescale 1ns/10ps
`default_nettype none
module table_memory (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// fetch port
	input  wire logic        fetch_req,
	input  wire logic [19:0] fetch_addr,
	input  wire logic [3:0]  delay,
	output var  logic [7:0]  fetch_data,
	output var  logic        fetch_valid
);
	logic [3:0] cnt;

	// data byte is a plain function of the address; between answers it toggles so stale data never looks valid
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			fetch_valid <= 1'b0;
			fetch_data <= 8'h00;
		end else if (fetch_req && !fetch_valid && cnt == delay) begin
			cnt <= 4'h0;
			fetch_valid <= 1'b1;
			fetch_data <= fetch_addr[7:0] ^ 8'h5a;
		end else begin
			fetch_valid <= 1'b0;
			fetch_data <= ~fetch_data;
			if (fetch_req && !fetch_valid) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/cpu_address_generation_test.sv */
// testbench for the address generator with a table memory partner
`timescale 1ns/10ps
`default_nettype none
module cpu_address_generation_test;
	import agen_pkg::*;
	logic clk_sys, rst_n, branch_req, branch_instr, call_via_pair, table_call_instr;
	logic operand_req, segment_prefix, pointer_is_main, index_is_c, unsigned_multiply_instr, stack_req;
	logic [5:0] branch_mode;
	logic [19:0] next_pc, branch_imm, pc_target, fetch_addr, operand_addr, stack_addr;
	logic [3:0] code_upper_nibble, operand_mode, data_upper_nibble_reg, delay;
	logic [1:0] branch_pair_sel, pair_field;
	logic [4:0] table_index;
	logic [7:0] fetch_data, operand_byte, reg_byte;
	logic [15:0] operand_imm, reg_pair, stack_pointer;
	logic [2:0] reg_field, stack_op;
	logic [63:0] bank_regs;
	logic fetch_valid, pc_load, fetch_req, operand_valid, implied_multiplier, stack_valid, stack_fault;
	int failures = 0;
	int comparisons = 0;

	cpu_address_generation DUT (.clk_sys(clk_sys), .rst_n(rst_n), .branch_req(branch_req),
		.branch_mode(branch_mode), .branch_instr(branch_instr), .next_pc(next_pc), .branch_imm(branch_imm),
		.code_upper_nibble(code_upper_nibble), .branch_pair_sel(branch_pair_sel), .call_via_pair(call_via_pair),
		.table_call_instr(table_call_instr), .table_index(table_index), .fetch_data(fetch_data),
		.fetch_valid(fetch_valid), .operand_req(operand_req), .operand_mode(operand_mode),
		.segment_prefix(segment_prefix), .data_upper_nibble_reg(data_upper_nibble_reg), .operand_imm(operand_imm),
		.operand_byte(operand_byte), .pointer_is_main(pointer_is_main), .index_is_c(index_is_c),
		.unsigned_multiply_instr(unsigned_multiply_instr), .reg_field(reg_field), .pair_field(pair_field),
		.bank_regs(bank_regs), .stack_req(stack_req), .stack_op(stack_op), .pc_load(pc_load),
		.pc_target(pc_target), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .operand_valid(operand_valid),
		.operand_addr(operand_addr), .implied_multiplier(implied_multiplier), .reg_byte(reg_byte),
		.reg_pair(reg_pair), .stack_valid(stack_valid), .stack_addr(stack_addr),
		.stack_pointer(stack_pointer), .stack_fault(stack_fault));

	table_memory memory (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.delay(delay), .fetch_data(fetch_data), .fetch_valid(fetch_valid));

	// ****************
	// helpers
	// ****************
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic br(input logic [5:0] m, input logic bi, input logic [19:0] imm, input logic [1:0] sel,
		input logic cv, input logic ok, input logic [19:0] exp);
		@(posedge clk_sys);
		branch_req <= 1'b1;
		branch_mode <= m;
		branch_instr <= bi;
		branch_imm <= imm;
		branch_pair_sel <= sel;
		call_via_pair <= cv;
		@(posedge clk_sys);
		branch_req <= 1'b0;
		#1;
		chk({19'h0, pc_load}, {19'h0, ok});
		if (ok) chk(pc_target, exp);
	endtask

	task automatic op(input logic [3:0] m, input logic pre, input logic main, input logic isc,
		input logic [15:0] imm, input logic [7:0] byt, input logic mul, input logic ok, input logic [19:0] exp);
		@(posedge clk_sys);
		operand_req <= 1'b1;
		operand_mode <= m;
		segment_prefix <= pre;
		pointer_is_main <= main;
		index_is_c <= isc;
		operand_imm <= imm;
		operand_byte <= byt;
		unsigned_multiply_instr <= mul;
		@(posedge clk_sys);
		operand_req <= 1'b0;
		unsigned_multiply_instr <= 1'b0;
		#1;
		chk({19'h0, operand_valid}, {19'h0, ok});
		chk({19'h0, implied_multiplier}, {19'h0, mul});
		if (ok) chk(operand_addr, exp);
	endtask

	task automatic tc(input logic [4:0] idx, input logic [3:0] dly, input logic [19:0] exp);
		int n;
		@(posedge clk_sys);
		delay <= dly;
		table_index <= idx;
		table_call_instr <= 1'b1;
		@(posedge clk_sys);
		table_call_instr <= 1'b0;
		#1;
		chk(fetch_addr, CALL_TABLE_BASE + {14'h0, idx, 1'b0});
		chk({19'h0, fetch_req}, 20'h00001);
		for (n = 0; n < 60 && pc_load !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		if (n == 60) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, pc_load, 1'b1);
			give_verdict;
		end
		chk(pc_target, exp);
		chk({19'h0, fetch_req}, 20'h00000);
	endtask

	// a refused access must keep the pointer; the address is only judged for accepted ones
	task automatic stk(input logic [2:0] o, input logic ok, input logic [15:0] sp, input logic [19:0] adr);
		@(posedge clk_sys);
		stack_req <= 1'b1;
		stack_op <= o;
		@(posedge clk_sys);
		stack_req <= 1'b0;
		#1;
		chk({19'h0, stack_fault}, {19'h0, !ok});
		chk({19'h0, stack_valid}, {19'h0, ok});
		chk({4'h0, stack_pointer}, {4'h0, sp});
		if (ok) chk(stack_addr, adr);
	endtask

	task automatic regs;
		@(posedge clk_sys);
		reg_field <= 3'h3;
		pair_field <= 2'h2;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({12'h0, reg_byte}, 20'h00044);
		chk({4'h0, reg_pair}, 20'h06655);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		{rst_n, branch_req, branch_instr, call_via_pair, table_call_instr, operand_req} = '0;
		{segment_prefix, pointer_is_main, index_is_c, unsigned_multiply_instr, stack_req} = '0;
		{branch_mode, branch_imm, operand_mode, branch_pair_sel, pair_field, table_index} = '0;
		{operand_byte, operand_imm, reg_field, stack_op, delay} = '0;
		next_pc = 20'h12345;
		code_upper_nibble = 4'h5;
		data_upper_nibble_reg = 4'h3;
		bank_regs = 64'h8877665544332211;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		br(BR_REL8, 1'b1, 20'h00080, 2'h0, 1'b0, 1'b1, 20'h122c5);
		br(BR_REL16, 1'b1, 20'h07fff, 2'h0, 1'b0, 1'b1, 20'h1a344);
		br(BR_REL16, 1'b0, 20'h00010, 2'h0, 1'b0, 1'b0, 20'h0);
		br(BR_NONE, 1'b1, 20'h00010, 2'h0, 1'b0, 1'b0, 20'h0);
		br(BR_IMM20, 1'b0, 20'habcde, 2'h0, 1'b0, 1'b1, 20'habcde);
		br(BR_IMM16, 1'b0, 20'habcde, 2'h0, 1'b0, 1'b1, 20'h0bcde);
		br(BR_REGPAIR, 1'b0, 20'h0, 2'h2, 1'b1, 1'b1, 20'h56655);
		br(BR_REGPAIR, 1'b0, 20'h0, 2'h0, 1'b0, 1'b1, 20'h52211);
		br(BR_REGPAIR, 1'b0, 20'h0, 2'h3, 1'b0, 1'b0, 20'h0);
		tc(5'h1f, 4'h1, 20'h0e5e4);
		tc(5'h00, 4'h6, 20'h0dbda);
		op(OP_DIRECT, 1'b0, 1'b0, 1'b0, 16'h1234, 8'h00, 1'b0, 1'b1, 20'hf1234);
		op(OP_DIRECT, 1'b1, 1'b0, 1'b0, 16'h1234, 8'h00, 1'b0, 1'b1, 20'h31234);
		op(OP_SHORT, 1'b1, 1'b0, 1'b0, 16'h0, 8'h05, 1'b0, 1'b1, 20'hffe25);
		op(OP_SHORT_W, 1'b0, 1'b0, 1'b0, 16'h0, 8'h06, 1'b0, 1'b1, 20'hffe26);
		op(OP_SPECIAL, 1'b0, 1'b0, 1'b0, 16'h0, 8'hff, 1'b0, 1'b1, 20'hfffff);
		op(OP_SPECIAL_W, 1'b0, 1'b0, 1'b0, 16'h0, 8'h20, 1'b0, 1'b1, 20'hfff20);
		op(OP_INDIRECT, 1'b0, 1'b1, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 20'hf8877);
		op(OP_INDIRECT, 1'b1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 20'h36655);
		op(OP_BASED_RP, 1'b0, 1'b0, 1'b0, 16'h0, 8'h80, 1'b0, 1'b1, 20'hf66d5);
		op(OP_BASED_SP, 1'b1, 1'b0, 1'b0, 16'h0, 8'h10, 1'b0, 1'b1, 20'hffe10);
		op(OP_STACK, 1'b1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 20'hffe00);
		op(OP_WORD_IDX8, 1'b0, 1'b0, 1'b0, 16'h1000, 8'h00, 1'b0, 1'b1, 20'hf1044);
		op(OP_WORD_IDX8, 1'b1, 1'b0, 1'b1, 16'h1000, 8'h00, 1'b0, 1'b1, 20'h31033);
		op(OP_WORD_BC, 1'b0, 1'b0, 1'b0, 16'h1000, 8'h00, 1'b0, 1'b1, 20'hf5433);
		op(OP_HL_IDX, 1'b0, 1'b0, 1'b1, 16'h0, 8'h00, 1'b0, 1'b1, 20'hf88aa);
		op(OP_HL_IDX, 1'b1, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b1, 20'h388bb);
		op(4'hd, 1'b0, 1'b0, 1'b0, 16'h0, 8'h00, 1'b0, 1'b0, 20'h0);
		op(OP_NONE, 1'b0, 1'b0, 1'b0, 16'h0, 8'h00, 1'b1, 1'b0, 20'h0);
		regs;
		stk(STK_PUSH, 1'b1, 16'hfdfe, 20'hffdfe);
		stk(STK_POP, 1'b1, 16'hfe00, 20'hffdfe);
		stk(STK_CALL, 1'b1, 16'hfdfc, 20'hffdfc);
		stk(STK_RET, 1'b1, 16'hfe00, 20'hffdfc);
		for (int k = 1; k <= 64; k++) begin
			stk(STK_RET, 1'b1, 16'hfe00 + 16'(4 * k), {4'hf, 16'hfe00 + 16'(4 * k - 4)});
		end
		stk(STK_RET, 1'b0, 16'hff00, 20'h00000);
		give_verdict;
	end
endmodule
`default_nettype wire
